//--- rtl/bcd_add_pkg.sv
package bcd_add_pkg;

    // Register map, byte addresses on the bus.
    localparam logic [7:0] OFF_OPWORD = 8'h00;
    localparam logic [7:0] OFF_FLAGS  = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_DREG   = 8'h40;
    localparam logic [7:0] OFF_AREG   = 8'h60;
    localparam logic [7:0] OFF_MEM    = 8'h80;

    // Flag positions inside the condition code flags register.
    localparam int FLAG_X = 4;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;
    localparam logic [4:0] FLAGS_RESET = 5'h00;

    // Status register bits.
    localparam int STAT_BUSY    = 0;
    localparam int STAT_ILLEGAL = 1;

    // Fixed parts of the operation word.
    localparam logic [3:0] OP_HI_PATTERN  = 4'hC;
    localparam logic [4:0] OP_MID_PATTERN = 5'h10;

    localparam logic [31:0] BYTE_STEP  = 32'h0000_0001;
    localparam int          MEM_AW     = 6;
    localparam logic [1:0]  HTRANS_SEQ = 2'h3;
    localparam logic [2:0]  HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic [2:0] dst;
        logic       rm;
        logic [2:0] src;
    } op_fields_t;

    typedef struct packed {
        logic       write;
        logic       word;
        logic       inRange;
        logic [7:0] addr;
    } bus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_DEC_SRC = 2'b01,
        ST_DEC_DST = 2'b10,
        ST_EXEC    = 2'b11
    } unit_state_t;

endpackage

//--- rtl/bcd_add_extend_unit.sv
// How it works
// [RULE1] Adds source, destination and extend flag in decimal, result to destination.
// [RULE2] Always a single byte of two decimal digits; no wider size.
// [RULE3] Register mode reads and writes the data registers named in the word.
// [RULE4] Memory mode predecrements both address registers and stores at destination.
// [RULE5] Extend flag copies carry; negative and overflow are left as they were.
// [RULE6] Zero flag clears on a nonzero result and otherwise keeps its value.
// [RULE7] Carry flag is set on a decimal carry out of the byte, else cleared.
// [RULE8] Word is recognised by bits 15..12 and 8..4; bits 11..9 name destination.
// [RULE9] Mode bit 0 means register to register, 1 means memory to memory.
// [RULE10] Bits 2..0 name the source, data or address register by mode.
// [RULE11] Digit sums above nine get six added and carry onward.
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module bcd_add_extend_unit (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata
);

    bcd_add_pkg::bus_req_t    reqQ;
    bcd_add_pkg::op_fields_t  opQ;
    bcd_add_pkg::unit_state_t stateQ;

    logic        wrPendQ;
    logic        rdPendQ;
    logic        illegalQ;
    logic [4:0]  flagsQ;
    logic [31:0] dReg [8];
    logic [31:0] aReg [8];
    logic [7:0]  mem  [1 << bcd_add_pkg::MEM_AW];

    logic        accept;
    logic        busWr;
    logic [7:0]  wAddr;
    logic        opStart;
    logic        opLegal;
    logic        execDone;
    logic [7:0]  srcByte;
    logic [7:0]  dstByte;
    logic [8:0]  bcdOut;
    logic [7:0]  result;
    logic        carry;
    logic [31:0] readMux;

    // Two-digit decimal add; returns {carry, byte}.
    // [RULE11] Plus-six digit correction.
    function automatic logic [8:0] bcd_add(input logic [7:0] a, input logic [7:0] b,
                                           input logic x);
        logic [4:0] lo;
        logic [4:0] hi;
        logic       loCarry;
        lo = 5'(a[3:0]) + 5'(b[3:0]) + 5'(x);
        loCarry = lo > 5'h09;
        if (loCarry) begin
            lo = lo + 5'h06;
        end
        hi = 5'(a[7:4]) + 5'(b[7:4]) + 5'(loCarry);
        if (hi > 5'h09) begin
            hi = hi + 5'h06;
        end
        return {hi > 5'h0F || hi[4], hi[3:0], lo[3:0]};
    endfunction

    assign accept   = hsel & hready & htrans[1];
    assign busWr    = wrPendQ & reqQ.inRange & reqQ.word;
    assign wAddr    = reqQ.addr;
    assign execDone = stateQ == bcd_add_pkg::ST_EXEC;
    // [RULE8] Fixed pattern check.
    assign opLegal  = hwdata[15:12] == bcd_add_pkg::OP_HI_PATTERN
                   && hwdata[8:4] == bcd_add_pkg::OP_MID_PATTERN;
    assign opStart  = busWr && wAddr == bcd_add_pkg::OFF_OPWORD
                   && stateQ == bcd_add_pkg::ST_IDLE;

    // Reads take one wait state so a write just before is always seen.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wrPendQ   <= 1'b0;
            rdPendQ   <= 1'b0;
            reqQ      <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else begin
            wrPendQ   <= accept & hwrite;
            rdPendQ   <= accept & ~hwrite;
            hreadyout <= ~(accept & ~hwrite);
            hresp     <= 1'b0;
            if (accept) begin
                reqQ <= '{write: hwrite,
                          word: hsize == bcd_add_pkg::HSIZE_WORD,
                          inRange: haddr[31:8] == 24'h00_0000,
                          addr: haddr[7:0]};
            end
            if (rdPendQ) begin
                hrdata <= readMux;
            end
        end
    end

    always_comb begin
        readMux = 32'h0000_0000;
        if (reqQ.inRange && reqQ.word) begin
            if (wAddr == bcd_add_pkg::OFF_OPWORD) begin
                readMux = {25'h000_0000, opQ};
            end else if (wAddr == bcd_add_pkg::OFF_FLAGS) begin
                readMux = {27'h000_0000, flagsQ};
            end else if (wAddr == bcd_add_pkg::OFF_STATUS) begin
                readMux = {30'h0000_0000, illegalQ, stateQ != bcd_add_pkg::ST_IDLE};
            end else if (wAddr[7:5] == bcd_add_pkg::OFF_DREG[7:5]) begin
                readMux = dReg[wAddr[4:2]];
            end else if (wAddr[7:5] == bcd_add_pkg::OFF_AREG[7:5]) begin
                readMux = aReg[wAddr[4:2]];
            end else if (wAddr[7:6] == bcd_add_pkg::OFF_MEM[7:6]) begin
                readMux = {mem[{wAddr[5:2], 2'h3}], mem[{wAddr[5:2], 2'h2}],
                           mem[{wAddr[5:2], 2'h1}], mem[{wAddr[5:2], 2'h0}]};
            end
        end
    end

    // Sequencer: memory mode spends two cycles on the predecrements.
    always_ff @(posedge mclk) begin
        if (rst) begin
            stateQ   <= bcd_add_pkg::ST_IDLE;
            opQ      <= '0;
            illegalQ <= 1'b0;
        end else begin
            unique case (stateQ)
                bcd_add_pkg::ST_IDLE: begin
                    if (opStart) begin
                        illegalQ <= ~opLegal;
                        if (opLegal) begin
                            // [RULE8] Field extraction.
                            opQ <= '{dst: hwdata[11:9], rm: hwdata[3], src: hwdata[2:0]};
                            // [RULE9] Mode selects path.
                            stateQ <= hwdata[3] ? bcd_add_pkg::ST_DEC_SRC
                                                : bcd_add_pkg::ST_EXEC;
                        end
                    end
                end
                bcd_add_pkg::ST_DEC_SRC: stateQ <= bcd_add_pkg::ST_DEC_DST;
                bcd_add_pkg::ST_DEC_DST: stateQ <= bcd_add_pkg::ST_EXEC;
                bcd_add_pkg::ST_EXEC:    stateQ <= bcd_add_pkg::ST_IDLE;
            endcase
        end
    end

    // [RULE10] Source by mode.
    assign srcByte = opQ.rm ? mem[aReg[opQ.src][bcd_add_pkg::MEM_AW-1:0]]
                            : dReg[opQ.src][7:0];
    // [RULE3] Destination by mode.
    assign dstByte = opQ.rm ? mem[aReg[opQ.dst][bcd_add_pkg::MEM_AW-1:0]]
                            : dReg[opQ.dst][7:0];
    // [RULE1] Decimal sum with extend.
    assign bcdOut  = bcd_add(srcByte, dstByte, flagsQ[bcd_add_pkg::FLAG_X]);
    assign result  = bcdOut[7:0];
    assign carry   = bcdOut[8];

    // The datapath wins over a bus write to any data register in its cycle.
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                dReg[i] <= 32'h0000_0000;
            end
        end else if (execDone && !opQ.rm) begin
            // [RULE2] Byte write only.
            dReg[opQ.dst][7:0] <= result;
        end else if (busWr && wAddr[7:5] == bcd_add_pkg::OFF_DREG[7:5]) begin
            dReg[wAddr[4:2]] <= hwdata;
        end
    end

    // Memory addresses use only the low address bits, so they alias.
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                aReg[i] <= 32'h0000_0000;
            end
        end else if (stateQ == bcd_add_pkg::ST_DEC_SRC) begin
            // [RULE4] Source predecrement.
            aReg[opQ.src] <= aReg[opQ.src] - bcd_add_pkg::BYTE_STEP;
        end else if (stateQ == bcd_add_pkg::ST_DEC_DST) begin
            aReg[opQ.dst] <= aReg[opQ.dst] - bcd_add_pkg::BYTE_STEP;
        end else if (busWr && wAddr[7:5] == bcd_add_pkg::OFF_AREG[7:5]) begin
            aReg[wAddr[4:2]] <= hwdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (execDone && opQ.rm) begin
            // [RULE4] Store at decremented address.
            mem[aReg[opQ.dst][bcd_add_pkg::MEM_AW-1:0]] <= result;
        end else if (busWr && wAddr[7:6] == bcd_add_pkg::OFF_MEM[7:6]) begin
            for (int b = 0; b < 4; b++) begin
                mem[{wAddr[5:2], 2'(b)}] <= hwdata[8*b +: 8];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            flagsQ <= bcd_add_pkg::FLAGS_RESET;
        end else if (execDone) begin
            // [RULE5] Extend follows carry.
            flagsQ[bcd_add_pkg::FLAG_X] <= carry;
            // [RULE7] Decimal carry out.
            flagsQ[bcd_add_pkg::FLAG_C] <= carry;
            // [RULE6] Zero only clears.
            if (result != 8'h00) begin
                flagsQ[bcd_add_pkg::FLAG_Z] <= 1'b0;
            end
        end else if (busWr && wAddr == bcd_add_pkg::OFF_FLAGS) begin
            flagsQ <= hwdata[4:0];
        end
    end

    // Checks.
    logic [31:0] srcAddr;
    logic [23:0] dstUpper;
    logic [8:0]  decValue;
    logic [31:0] dstAddr;
    logic [31:0] srcReg;
    assign srcAddr  = aReg[opQ.src];
    assign dstAddr  = aReg[opQ.dst];
    assign srcReg   = dReg[opQ.src];
    assign dstUpper = dReg[opQ.dst][31:8];
    assign decValue = 9'(srcByte[7:4]) * 9'h00A + 9'(srcByte[3:0])
                    + 9'(dstByte[7:4]) * 9'h00A + 9'(dstByte[3:0])
                    + 9'(flagsQ[bcd_add_pkg::FLAG_X]);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence memSteps;
        stateQ == bcd_add_pkg::ST_DEC_SRC ##1 stateQ == bcd_add_pkg::ST_DEC_DST
            ##1 stateQ == bcd_add_pkg::ST_EXEC;
    endsequence

    sequence regSteps;
        stateQ == bcd_add_pkg::ST_EXEC ##1 stateQ == bcd_add_pkg::ST_IDLE;
    endsequence

    chk_extend_copies_carry: assert property ( // [RULE5]
        execDone |=> flagsQ[bcd_add_pkg::FLAG_X] == flagsQ[bcd_add_pkg::FLAG_C])
        else $error("Extend flag differs from carry.");

    chk_zero_kept: assert property ( // [RULE6]
        execDone && result == 8'h00 |=> $stable(flagsQ[bcd_add_pkg::FLAG_Z]))
        else $error("Zero flag changed on zero result.");

    chk_zero_cleared: assert property ( // [RULE6]
        execDone && result != 8'h00 |=> !flagsQ[bcd_add_pkg::FLAG_Z])
        else $error("Zero flag not cleared on nonzero result.");

    chk_carry_over_hundred: assert property ( // [RULE7]
        execDone |=> flagsQ[bcd_add_pkg::FLAG_C] == ($past(decValue) > 9'h063))
        else $error("Carry flag wrong for decimal sum.");

    chk_digit_correction: assert property ( // [RULE11]
        execDone && decValue < 9'h064
            |-> result == {4'(decValue / 9'h00A), 4'(decValue % 9'h00A)})
        else $error("Decimal digits wrong.");

    chk_reg_result: assert property ( // [RULE3]
        execDone && !opQ.rm |=> dReg[opQ.dst][7:0] == $past(result))
        else $error("Data register not written with result.");

    chk_byte_only: assert property ( // [RULE2]
        execDone && !opQ.rm |=> dReg[opQ.dst][31:8] == $past(dstUpper))
        else $error("Upper bytes of destination changed.");

    chk_mem_sequence: assert property ( // [RULE9]
        opStart && opLegal && hwdata[3] |=> memSteps ##1 stateQ == bcd_add_pkg::ST_IDLE)
        else $error("Memory mode sequence broken.");

    chk_reg_sequence: assert property ( // [RULE9]
        opStart && opLegal && !hwdata[3] |=> regSteps)
        else $error("Register mode sequence broken.");

    chk_predecrement: assert property ( // [RULE4]
        stateQ == bcd_add_pkg::ST_DEC_SRC |=> srcAddr == $past(srcAddr) - bcd_add_pkg::BYTE_STEP)
        else $error("Source address not decremented.");

    chk_mem_store: assert property ( // [RULE4]
        execDone && opQ.rm |=> mem[aReg[opQ.dst][bcd_add_pkg::MEM_AW-1:0]] == $past(result))
        else $error("Memory result not stored.");

    chk_decode_reject: assert property ( // [RULE8]
        opStart && !opLegal |=> stateQ == bcd_add_pkg::ST_IDLE && illegalQ)
        else $error("Illegal word not rejected.");

    // A read costs exactly one wait state, so a write just before it is always visible.
    sequence readWait;
        !hreadyout ##1 hreadyout;
    endsequence

    chk_read_one_wait: assert property (
        accept && !hwrite |=> readWait)
        else $error("Read wait state wrong.");

    chk_write_no_wait: assert property (
        accept && hwrite |=> hreadyout)
        else $error("Write data phase stalled.");

    chk_read_data_held: assert property (
        !rdPendQ |=> $stable(hrdata))
        else $error("Read data changed outside a read.");

    chk_dst_predecrement: assert property ( // [RULE4]
        stateQ == bcd_add_pkg::ST_DEC_DST |=> dstAddr == $past(dstAddr) - bcd_add_pkg::BYTE_STEP)
        else $error("Destination address not decremented.");

    chk_illegal_op_kept: assert property ( // [RULE8]
        opStart && !opLegal |=> $stable(opQ))
        else $error("Illegal word changed the decoded fields.");

    chk_legal_clears_flag: assert property ( // [RULE8]
        opStart && opLegal |=> !illegalQ)
        else $error("Legal word left the illegal flag set.");

    chk_field_decode: assert property ( // [RULE10]
        opStart && opLegal |=> opQ.src == $past(hwdata[2:0]) && opQ.rm == $past(hwdata[3])
            && opQ.dst == $past(hwdata[11:9]))
        else $error("Operation word fields decoded wrongly.");

    chk_nv_kept: assert property ( // [RULE5]
        execDone |=> flagsQ[bcd_add_pkg::FLAG_N] == $past(flagsQ[bcd_add_pkg::FLAG_N])
            && flagsQ[bcd_add_pkg::FLAG_V] == $past(flagsQ[bcd_add_pkg::FLAG_V]))
        else $error("Negative or overflow flag changed.");

    chk_src_untouched: assert property ( // [RULE3]
        execDone && !opQ.rm && opQ.src != opQ.dst |=> srcReg == $past(srcReg))
        else $error("Source data register changed.");

endmodule

`default_nettype wire

//--- verification/tb_bcd_add_extend_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bcd_add_extend_unit;
    logic        mclk      = 1'b0;
    logic        rst       = 1'b1;
    logic        hsel      = 1'b1;
    logic [31:0] haddr     = 32'h0;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [2:0]  hsize     = 3'h2;
    logic [31:0] hwdata    = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [7:0]  mem [64];
    int          failCount = 0;
    int          checks    = 0;

    always #12.5 mclk = ~mclk;

    bcd_add_extend_unit DUT (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    task automatic end_of_test;
        if (failCount == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic bad(input string what);
        failCount++;
        $display("BAD %0t %s", $time, what);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) bad($sformatf("%s got %h exp %h", what, got, exp));
    endtask

    // The single slave's hreadyout is hready, so it is sampled at each rising edge.
    task automatic waitReady;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            bad("bus hang");
            end_of_test();
        end
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        waitReady();
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0, "hresp");
    endtask

    function automatic logic [31:0] ad(input logic [7:0] o, input int n);
        return {24'h0, o} + 32'(4 * n);
    endfunction

    // Decimal reference built from whole numbers, not from digit correction.
    function automatic logic [8:0] bcdSum(input logic [7:0] a, input logic [7:0] b,
                                          input logic x);
        int s;
        s = 10 * a[7:4] + a[3:0] + 10 * b[7:4] + b[3:0] + x;
        return {s > 99, 4'(s % 100 / 10), 4'(s % 10)};
    endfunction

    function automatic logic [31:0] expFlags(input logic [4:0] f, input logic [8:0] r);
        logic [4:0] e;
        e = f;
        e[bcd_add_pkg::FLAG_X] = r[8];
        e[bcd_add_pkg::FLAG_C] = r[8];
        if (r[7:0] != 8'h00) e[bcd_add_pkg::FLAG_Z] = 1'b0;
        return {27'h0, e};
    endfunction

    function automatic logic [7:0] rbcd();
        return {4'($urandom_range(9)), 4'($urandom_range(9))};
    endfunction

    function automatic logic [31:0] memWord(input logic [3:0] k);
        return {mem[{k, 2'h3}], mem[{k, 2'h2}], mem[{k, 2'h1}], mem[{k, 2'h0}]};
    endfunction

    task automatic runOp(input logic [2:0] d, input logic m, input logic [2:0] s,
                         input logic [4:0] mid);
        int n;
        n = 0;
        xfer(1'b1, ad(bcd_add_pkg::OFF_OPWORD, 0),
             {16'h0, bcd_add_pkg::OP_HI_PATTERN, d, mid, m, s});
        do begin
            xfer(1'b0, ad(bcd_add_pkg::OFF_STATUS, 0), 32'h0);
            n++;
        end while (rd[bcd_add_pkg::STAT_BUSY] !== 1'b0 && n < 10);
        if (rd[bcd_add_pkg::STAT_BUSY] !== 1'b0) begin
            bad("busy stuck");
            end_of_test();
        end
    endtask

    task automatic regCase(input logic [2:0] d, input logic [2:0] s, input logic [7:0] a,
                           input logic [7:0] b, input logic [4:0] f);
        logic [31:0] up;
        logic [8:0]  r;
        up = $urandom();
        r  = bcdSum((s == d) ? b : a, b, f[bcd_add_pkg::FLAG_X]);
        xfer(1'b1, ad(bcd_add_pkg::OFF_DREG, s), {24'($urandom()), a});
        xfer(1'b1, ad(bcd_add_pkg::OFF_DREG, d), {up[31:8], b});
        xfer(1'b1, ad(bcd_add_pkg::OFF_FLAGS, 0), {27'h0, f});
        runOp(d, 1'b0, s, bcd_add_pkg::OP_MID_PATTERN);
        chk(rd, 32'h0, "status");
        xfer(1'b0, ad(bcd_add_pkg::OFF_DREG, d), 32'h0);
        chk(rd, {up[31:8], r[7:0]}, "dreg");
        xfer(1'b0, ad(bcd_add_pkg::OFF_FLAGS, 0), 32'h0);
        chk(rd, expFlags(f, r), "flags");
    endtask

    task automatic memCase(input logic [2:0] s, input logic [2:0] d, input logic [4:0] f);
        logic [31:0] as;
        logic [31:0] av;
        logic [5:0]  is;
        logic [5:0]  id;
        logic [8:0]  r;
        as = $urandom();
        av = as + 32'($urandom_range(62, 1));
        is = 6'(as - 32'h1);
        id = 6'(av - 32'h1);
        r  = bcdSum(mem[is], mem[id], f[bcd_add_pkg::FLAG_X]);
        mem[id] = r[7:0];
        xfer(1'b1, ad(bcd_add_pkg::OFF_AREG, s), as);
        xfer(1'b1, ad(bcd_add_pkg::OFF_AREG, d), av);
        xfer(1'b1, ad(bcd_add_pkg::OFF_FLAGS, 0), {27'h0, f});
        runOp(d, 1'b1, s, bcd_add_pkg::OP_MID_PATTERN);
        xfer(1'b0, ad(bcd_add_pkg::OFF_MEM, int'(id[5:2])), 32'h0);
        chk(rd, memWord(id[5:2]), "mem");
        xfer(1'b0, ad(bcd_add_pkg::OFF_AREG, s), 32'h0);
        chk(rd, as - 32'h1, "asrc");
        xfer(1'b0, ad(bcd_add_pkg::OFF_AREG, d), 32'h0);
        chk(rd, av - 32'h1, "adst");
        xfer(1'b0, ad(bcd_add_pkg::OFF_FLAGS, 0), 32'h0);
        chk(rd, expFlags(f, r), "mflags");
    endtask

    initial begin
        void'($urandom(39859));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        xfer(1'b0, ad(bcd_add_pkg::OFF_FLAGS, 0), 32'h0);
        chk(rd, 32'h0, "flags reset");
        xfer(1'b0, 32'h0000_0100, 32'h0);
        chk(rd, 32'h0, "unmapped");
        for (int k = 0; k < 64; k++) mem[k] = rbcd();
        for (int k = 0; k < 16; k++) xfer(1'b1, ad(bcd_add_pkg::OFF_MEM, k), memWord(4'(k)));
        regCase(3'h1, 3'h2, 8'h99, 8'h99, 5'h10);
        regCase(3'h3, 3'h4, 8'h00, 8'h00, 5'h04);
        regCase(3'h5, 3'h6, 8'h50, 8'h49, 5'h1F);
        regCase(3'h7, 3'h7, 8'h45, 8'h45, 5'h0B);
        regCase(3'h0, 3'h0, 8'h09, 8'h09, 5'h10);
        for (int k = 0; k < 20; k++) regCase(3'($urandom()), 3'($urandom()), rbcd(), rbcd(),
                                             5'($urandom()));
        for (int k = 0; k < 10; k++) begin
            logic [2:0] s;
            s = 3'($urandom());
            memCase(s, s ^ 3'($urandom_range(7, 1)), 5'($urandom()));
        end
        // A reset in mid-run must clear the registers that the operations filled.
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        xfer(1'b0, ad(bcd_add_pkg::OFF_AREG, 3), 32'h0);
        chk(rd, 32'h0, "areg reset");
        xfer(1'b0, ad(bcd_add_pkg::OFF_DREG, 5), 32'h0);
        chk(rd, 32'h0, "dreg reset");
        xfer(1'b0, ad(bcd_add_pkg::OFF_FLAGS, 0), 32'h0);
        chk(rd, 32'h0, "flags reset again");
        xfer(1'b1, ad(bcd_add_pkg::OFF_DREG, 2), 32'h0000_0011);
        runOp(3'd2, 1'b0, 3'd1, bcd_add_pkg::OP_MID_PATTERN ^ 5'h01);
        chk(rd, 32'h2, "illegal status");
        xfer(1'b0, ad(bcd_add_pkg::OFF_DREG, 2), 32'h0);
        chk(rd, 32'h0000_0011, "illegal kept");
        regCase(3'd2, 3'd1, 8'h12, 8'h34, 5'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
